/* File: src/mac_receive_control_pkg.sv */
// Functional notes
// - Hold 14-bit maximum frame length at bits 29:16, default 1518; flag longer frames as long.
// - Watchdog truncates and aborts any frame longer than 11,264 bytes.
// - Truncation select 0 cuts at maximum plus one; status shows long flag, length.
// - Truncation select 1 (default) cuts at 11265; status shows long and watchdog flags.
// - FCS stripping set removes the last four bytes of every frame.
// - VLAN enforcement 0 flags every frame above the maximum as long.
// - VLAN enforcement 1 allows 4 extra bytes per tag, up to two tags.
// - Disabled flag sets when disable sequence completes; write one clears; resets 0.
// - Receive enable accepts frames when set, none when clear; resets 0.
// - Clearing enable mid-frame finishes that frame, then stops and flags disabled.
package mac_receive_control_pkg;

    // Register byte addresses
    localparam logic [11:0] ADDR_RX_CTRL = 12'h104;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h120;
    localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h124;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h128;

    // Receive control field positions
    localparam int MAXLEN_LSB = 16;
    localparam int MAXLEN_W = 14;
    localparam int BIT_TRUNC = 5;
    localparam int BIT_STRIP = 4;
    localparam int BIT_VLAN = 2;
    localparam int BIT_RXD = 1;
    localparam int BIT_EN = 0;

    // Reset values
    localparam logic [13:0] MAXLEN_RST = 14'h05EE;
    localparam logic TRUNC_RST = 1'h1;
    localparam logic STRIP_RST = 1'h0;
    localparam logic VLAN_RST = 1'h0;
    localparam logic RXD_RST = 1'h0;
    localparam logic EN_RST = 1'h0;
    localparam logic [3:0] IRQ_EN_RST = 4'h0;

    // Length limits
    localparam logic [14:0] WDOG_CUT = 15'h2C01;
    localparam int HOLD_DEPTH = 5;
    localparam logic [2:0] HOLD_FULL = 3'h5;

    // VLAN tag detection
    localparam logic [15:0] TPID_CTAG = 16'h8100;
    localparam logic [15:0] TPID_STAG = 16'h88A8;
    localparam logic [13:0] TAG1_HI_IDX = 14'h000C;
    localparam logic [13:0] TAG2_HI_IDX = 14'h0010;

    // Status word layout
    localparam int ST_LEN_LSB = 0;
    localparam int ST_LONG = 16;
    localparam int ST_WDOG = 17;
    localparam int ST_FCS = 18;
    localparam int ST_VLAN1 = 19;
    localparam int ST_VLAN2 = 20;

    // Interrupt status bits
    localparam int IRQ_W = 4;
    localparam int IRQ_FRAME = 0;
    localparam int IRQ_LONG = 1;
    localparam int IRQ_WDOG = 2;
    localparam int IRQ_RXD = 3;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RECV = 4'h2,
        ST_FLUSH = 4'h4,
        ST_DROP = 4'h8
    } rx_state_t;

endpackage

/* File: src/byte_hold_line.sv */
`timescale 1ns/1ps
module byte_hold_line
    import mac_receive_control_pkg::*;
#(
    parameter int DEPTH = HOLD_DEPTH
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic push,
    input wire logic pop,
    input wire logic clear,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic [2:0] count
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [2:0] cnt;
    } hold_t;

    hold_t r_q;
    hold_t r_d;

    // Oldest byte held; newest sits at index zero
    assign dataOut = (r_q.cnt != 3'h0) ? r_q.mem[r_q.cnt - 3'h1] : 8'h00;
    assign count = r_q.cnt;

    // Shift in on push, drop oldest on pop, empty on clear
    always_comb begin
        r_d = r_q;
        if (clear) begin
            r_d.cnt = 3'h0;
        end else if (push) begin
            r_d.mem = {r_q.mem[DEPTH-2:0], dataIn};
            if (r_q.cnt != 3'(DEPTH)) begin
                r_d.cnt = r_q.cnt + 3'h1;
            end
        end else if (pop && r_q.cnt != 3'h0) begin
            r_d.cnt = r_q.cnt - 3'h1;
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end
endmodule

/* File: src/vlan_tag_detect.sv */
`timescale 1ns/1ps
module vlan_tag_detect
    import mac_receive_control_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic start,
    input wire logic byteValid,
    input wire logic [13:0] byteIdx,
    input wire logic [7:0] byteData,
    output logic [1:0] tagCount
);
    typedef struct packed {
        logic [7:0] hi;
        logic [1:0] tags;
    } tag_t;

    tag_t r_q;
    tag_t r_d;
    logic [15:0] tpid;

    assign tagCount = r_q.tags;
    assign tpid = {r_q.hi, byteData};

    // Count stacked tags at the two tag positions
    always_comb begin
        r_d = r_q;
        if (start) begin
            r_d.tags = 2'h0;
        end
        if (byteValid) begin
            if (byteIdx == TAG1_HI_IDX || byteIdx == TAG2_HI_IDX) begin
                r_d.hi = byteData;
            end
            if (byteIdx == TAG1_HI_IDX + 14'h0001 && (tpid == TPID_CTAG || tpid == TPID_STAG)) begin
                r_d.tags = 2'h1;
            end
            if (byteIdx == TAG2_HI_IDX + 14'h0001 && r_q.tags == 2'h1
                    && (tpid == TPID_CTAG || tpid == TPID_STAG)) begin
                r_d.tags = 2'h2;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end
endmodule

/* File: src/mac_receive_control.sv */
`timescale 1ns/1ps
module mac_receive_control
    import mac_receive_control_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [11:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic rxDv,
    input wire logic [7:0] rxData,
    input wire logic rxFcsBad,
    output logic outValid,
    output logic [7:0] outData,
    output logic outLast,
    output logic statusValid,
    output logic [31:0] statusWord,
    output logic irq
);
    typedef struct packed {
        rx_state_t st;
        logic [13:0] maxLen;
        logic trunc;
        logic strip;
        logic vlanEn;
        logic rxDisabled;
        logic rx_enable_bit;
        logic pendDis;
        logic dvPrev;
        logic [13:0] byteCnt;
        logic longF;
        logic wdogF;
        logic fcsF;
        logic dropRest;
        logic [IRQ_W-1:0] irqStat;
        logic [IRQ_W-1:0] irqEn;
        logic [31:0] rdData;
        logic oValid;
        logic [7:0] oData;
        logic oLast;
        logic sValid;
        logic [31:0] sWord;
        logic irqOut;
    } ctrl_t;

    ctrl_t r_q;
    ctrl_t r_d;

    logic push;
    logic pop;
    logic clr;
    logic vStart;
    logic [7:0] holdOut;
    logic [2:0] holdCnt;
    logic [1:0] tags;
    logic [13:0] vIdx;
    logic [14:0] newCnt;
    logic [14:0] effLimit;
    logic finish;
    logic [IRQ_W-1:0] ev;

    // Outputs straight from the state register
    assign regRdData = r_q.rdData;
    assign outValid = r_q.oValid;
    assign outData = r_q.oData;
    assign outLast = r_q.oLast;
    assign statusValid = r_q.sValid;
    assign statusWord = r_q.sWord;
    assign irq = r_q.irqOut;

    // Holds the last bytes so the FCS can be dropped at frame end
    byte_hold_line #(
        .DEPTH(HOLD_DEPTH)
    ) u_hold (
        .clk_sys(clk_sys),
        .reset(reset),
        .push(push),
        .pop(pop),
        .clear(clr),
        .dataIn(rxData),
        .dataOut(holdOut),
        .count(holdCnt)
    );

    // Counts VLAN tags of the frame in progress
    vlan_tag_detect u_vlan (
        .clk_sys(clk_sys),
        .reset(reset),
        .start(vStart),
        .byteValid(push),
        .byteIdx(vIdx),
        .byteData(rxData),
        .tagCount(tags)
    );

    // First byte of a frame has index zero, not the stale count
    assign vIdx = vStart ? 14'h0000 : r_q.byteCnt;

    // Byte count after this byte and the size limit for this frame
    assign newCnt = {1'b0, r_q.byteCnt} + 15'h0001;
    assign effLimit = {1'b0, r_q.maxLen}
        + (r_q.vlanEn ? {11'h000, tags, 2'b00} : 15'h0000);

    // Register access, receive sequencing and interrupts
    always_comb begin
        r_d = r_q;
        r_d.oValid = 1'b0;
        r_d.oLast = 1'b0;
        r_d.sValid = 1'b0;
        r_d.dvPrev = rxDv;
        r_d.rdData = 32'h0000_0000;
        push = 1'b0;
        pop = 1'b0;
        clr = 1'b0;
        vStart = 1'b0;
        finish = 1'b0;
        ev = '0;

        // Register writes; hardware sets below take priority over clears
        if (regWr) begin
            unique case (regAddr)
                ADDR_RX_CTRL: begin
                    r_d.maxLen = regWrData[MAXLEN_LSB +: MAXLEN_W];
                    r_d.trunc = regWrData[BIT_TRUNC];
                    r_d.strip = regWrData[BIT_STRIP];
                    r_d.vlanEn = regWrData[BIT_VLAN];
                    r_d.rx_enable_bit = regWrData[BIT_EN];
                    if (regWrData[BIT_RXD]) begin
                        r_d.rxDisabled = 1'b0;
                    end
                    if (r_q.rx_enable_bit && !regWrData[BIT_EN]) begin
                        r_d.pendDis = 1'b1;
                    end
                    if (regWrData[BIT_EN]) begin
                        r_d.pendDis = 1'b0;
                    end
                end
                ADDR_IRQ_CLEAR: begin
                    r_d.irqStat = r_q.irqStat & ~regWrData[IRQ_W-1:0];
                end
                ADDR_IRQ_ENABLE: begin
                    r_d.irqEn = regWrData[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Receive sequence
        unique case (r_q.st)
            ST_IDLE: begin
                if (r_q.rx_enable_bit && rxDv && !r_q.dvPrev) begin
                    vStart = 1'b1;
                    push = 1'b1;
                    r_d.byteCnt = 14'h0001;
                    r_d.longF = 1'b0;
                    r_d.wdogF = 1'b0;
                    r_d.fcsF = 1'b0;
                    r_d.dropRest = 1'b0;
                    r_d.st = ST_RECV;
                end else if (r_q.pendDis) begin
                    r_d.pendDis = 1'b0;
                    r_d.rxDisabled = 1'b1;
                    ev[IRQ_RXD] = 1'b1;
                end
            end
            ST_RECV: begin
                if (!rxDv) begin
                    r_d.fcsF = r_q.fcsF | rxFcsBad;
                    r_d.st = ST_FLUSH;
                end else begin
                    push = 1'b1;
                    r_d.byteCnt = newCnt[13:0];
                    if (newCnt > effLimit) begin
                        r_d.longF = 1'b1;
                    end
                    if (newCnt == WDOG_CUT) begin
                        r_d.longF = 1'b1;
                        r_d.wdogF = 1'b1;
                        r_d.fcsF = 1'b1;
                        r_d.dropRest = 1'b1;
                        r_d.st = ST_FLUSH;
                    end else if (!r_q.trunc && newCnt > effLimit) begin
                        r_d.fcsF = 1'b1;
                        r_d.dropRest = 1'b1;
                        r_d.st = ST_FLUSH;
                    end
                    if (holdCnt == HOLD_FULL) begin
                        r_d.oValid = 1'b1;
                        r_d.oData = holdOut;
                    end
                end
            end
            ST_FLUSH: begin
                if (r_q.strip) begin
                    // Four held bytes are the FCS and are discarded
                    clr = 1'b1;
                    finish = 1'b1;
                    if (holdCnt == HOLD_FULL) begin
                        r_d.oValid = 1'b1;
                        r_d.oData = holdOut;
                        r_d.oLast = 1'b1;
                    end
                end else begin
                    pop = 1'b1;
                    finish = (holdCnt <= 3'h1);
                    if (holdCnt != 3'h0) begin
                        r_d.oValid = 1'b1;
                        r_d.oData = holdOut;
                        r_d.oLast = (holdCnt == 3'h1);
                    end
                end
                if (finish) begin
                    r_d.sValid = 1'b1;
                    r_d.sWord = 32'h0000_0000;
                    r_d.sWord[ST_LEN_LSB +: MAXLEN_W] = r_q.byteCnt;
                    r_d.sWord[ST_LONG] = r_q.longF;
                    r_d.sWord[ST_WDOG] = r_q.wdogF;
                    r_d.sWord[ST_FCS] = r_q.fcsF;
                    r_d.sWord[ST_VLAN1] = (tags != 2'h0);
                    r_d.sWord[ST_VLAN2] = (tags == 2'h2);
                    ev[IRQ_FRAME] = 1'b1;
                    ev[IRQ_LONG] = r_q.longF;
                    ev[IRQ_WDOG] = r_q.wdogF;
                    r_d.st = r_q.dropRest ? ST_DROP : ST_IDLE;
                end
            end
            ST_DROP: begin
                // Rest of a truncated frame is discarded
                if (!rxDv) begin
                    r_d.st = ST_IDLE;
                end
            end
            default: begin
                r_d.st = ST_IDLE;
            end
        endcase

        // Sticky events and interrupt output
        r_d.irqStat = r_d.irqStat | ev;
        r_d.irqOut = |(r_d.irqStat & r_d.irqEn);

        // Read data valid in the cycle after the strobe
        if (regRd) begin
            unique case (regAddr)
                ADDR_RX_CTRL: begin
                    r_d.rdData[MAXLEN_LSB +: MAXLEN_W] = r_q.maxLen;
                    r_d.rdData[BIT_TRUNC] = r_q.trunc;
                    r_d.rdData[BIT_STRIP] = r_q.strip;
                    r_d.rdData[BIT_VLAN] = r_q.vlanEn;
                    r_d.rdData[BIT_RXD] = r_q.rxDisabled;
                    r_d.rdData[BIT_EN] = r_q.rx_enable_bit;
                end
                ADDR_IRQ_STATUS: begin
                    r_d.rdData[IRQ_W-1:0] = r_q.irqStat;
                end
                ADDR_IRQ_ENABLE: begin
                    r_d.rdData[IRQ_W-1:0] = r_q.irqEn;
                end
                default: begin
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            r_q <= '0;
            r_q.st <= ST_IDLE;
            r_q.maxLen <= MAXLEN_RST;
            r_q.trunc <= TRUNC_RST;
            r_q.strip <= STRIP_RST;
            r_q.vlanEn <= VLAN_RST;
            r_q.rxDisabled <= RXD_RST;
            r_q.rx_enable_bit <= EN_RST;
            r_q.irqEn <= IRQ_EN_RST;
        end else begin
            r_q <= r_d;
        end
    end
endmodule

/* File: testbench/mac_receive_control_props.sv */
`timescale 1ns/1ps
module mac_receive_control_props
    import mac_receive_control_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    input wire logic rxDv,
    input wire logic outValid,
    input wire logic outLast,
    input wire logic statusValid,
    input wire logic [31:0] statusWord,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    // Bus, length and tag relations
    a_read_idle_zero: assert property (
        !$past(regRd) |-> regRdData == 32'h0) else $error("read data outside read cycle");
    a_wdog_cut_flags: assert property (
        statusValid && statusWord[ST_WDOG] |-> statusWord[ST_LONG] && statusWord[ST_FCS]
        && statusWord[13:0] == 14'h2C01) else $error("watchdog status incomplete");
    a_len_never_over: assert property (
        statusValid |-> statusWord[13:0] <= 14'h2C01) else $error("length past watchdog cut");
    a_two_tags_one: assert property (
        statusValid && statusWord[ST_VLAN2] |-> statusWord[ST_VLAN1])
        else $error("double tag without single tag");
    // Frame delivery relations
    a_last_with_status: assert property (
        outLast |-> outValid && statusValid) else $error("last byte without status");
    a_status_word_hold: assert property (
        !statusValid |-> $stable(statusWord)) else $error("status word moved");
    a_status_one_pulse: assert property (
        statusValid |=> !statusValid [*3]) else $error("status strobe repeated");
    a_out_after_rx: assert property (
        $rose(outValid) |-> $past(rxDv, 2) || $past(rxDv, 3) || $past(rxDv, 4))
        else $error("output without received bytes");

    c_wdog: cover property (statusValid && statusWord[ST_WDOG]);
    c_two_tags: cover property (statusValid && statusWord[ST_VLAN2]);
    c_irq: cover property ($rose(irq));
endmodule

bind mac_receive_control mac_receive_control_props u_props (.clk_sys(clk_sys), .reset(reset),
    .regRd(regRd), .regRdData(regRdData), .rxDv(rxDv), .outValid(outValid),
    .outLast(outLast), .statusValid(statusValid), .statusWord(statusWord), .irq(irq));

/* File: testbench/phy_line_model.sv */
`timescale 1ns/1ps
module phy_line_model (
    input wire logic clk_sys,
    output logic rxDv,
    output logic [7:0] rxData,
    output logic rxFcsBad
);
    // Set by the bench to flag the next frame's FCS as bad
    logic badFcs = 1'b0;
    initial begin
        rxDv = 1'b0;
        rxData = 8'h00;
        rxFcsBad = 1'b0;
    end

    // One frame: count pattern, tag ids at 12 and 16, then idle gap
    task automatic send(input int len, input int tags);
        logic [7:0] b;
        for (int i = 0; i < len; i++) begin
            b = i[7:0];
            if (tags == 1 && i == 12) b = 8'h81;
            if (tags == 2 && i == 12) b = 8'h88;
            if (tags == 2 && i == 13) b = 8'hA8;
            if (tags == 2 && i == 16) b = 8'h81;
            if (tags > 0 && (i == 13 && tags == 1 || i == 17)) b = 8'h00;
            @(posedge clk_sys);
            rxDv <= 1'b1;
            rxData <= b;
        end
        // Gap of 12 idle cycles, data toggling so stale bytes never repeat
        for (int g = 0; g < 12; g++) begin
            @(posedge clk_sys);
            rxDv <= 1'b0;
            rxData <= ~rxData;
            rxFcsBad <= (g == 0) ? badFcs : 1'b0;
        end
    endtask
endmodule

/* File: testbench/mac_receive_control_test.sv */
`timescale 1ns/1ps
module mac_receive_control_test;
    import mac_receive_control_pkg::*;
    logic clk_sys, reset, regWr, regRd, rxDv, rxFcsBad, outValid, outLast, statusValid, irq;
    logic [11:0] regAddr;
    logic [31:0] regWrData, regRdData, statusWord, stat;
    logic [7:0] rxData, outData;
    logic [7:0] got[$];
    int nStat, nLast, checks, failures;

    mac_receive_control u_dut (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .rxDv(rxDv), .rxData(rxData), .rxFcsBad(rxFcsBad), .outValid(outValid),
        .outData(outData), .outLast(outLast), .statusValid(statusValid),
        .statusWord(statusWord), .irq(irq));
    phy_line_model u_phy (.clk_sys(clk_sys), .rxDv(rxDv), .rxData(rxData),
        .rxFcsBad(rxFcsBad));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Collect delivered bytes and the latest status word
    always @(posedge clk_sys) begin
        if (outValid) got.push_back(outData);
        if (outValid && outLast) nLast++;
        if (statusValid) begin
            stat = statusWord;
            nStat++;
        end
    end

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(negedge clk_sys);
        check(n, regRdData, e);
    endtask

    // Settings go in while disabled, then enable follows
    task automatic cfg(input logic [13:0] m, input logic [5:0] b);
        wr(ADDR_RX_CTRL, {2'h0, m, 10'h000, b & 6'h3E});
        wr(ADDR_RX_CTRL, {2'h0, m, 10'h000, b});
    endtask

    task automatic frame(input int len, input int tags, input bit want);
        got.delete();
        nStat = 0;
        nLast = 0;
        u_phy.send(len, tags);
        for (int k = 0; k < 40 && nStat == 0; k++) @(posedge clk_sys);
        if (want && nStat == 0) begin
            failures++;
            summarize();
        end
    endtask

    task automatic t_regs();
        rd(ADDR_RX_CTRL, 32'h05EE0020, "ctrl reset");
        rd(ADDR_IRQ_ENABLE, 32'h0, "irq enable reset");
        wr(ADDR_RX_CTRL, 32'hC5EEFFE8);
        rd(ADDR_RX_CTRL, 32'h05EE0020, "reserved bits");
        rd(12'h200, 32'h0, "unmapped");
    endtask

    task automatic t_pass();
        cfg(14'h05EE, 6'h01);
        frame(64, 0, 1'b1);
        check("plain count", 32'(got.size()), 32'h40);
        check("plain last", {24'h0, got[63]}, 32'h3F);
        check("plain status", stat & 32'h1F3FFF, 32'h40);
        check("plain outlast", 32'(nLast), 32'h1);
        u_phy.badFcs = 1'b1;
        frame(64, 0, 1'b1);
        u_phy.badFcs = 1'b0;
        check("fcs flag", stat & 32'h1F3FFF, 32'h40040);
        cfg(14'h05EE, 6'h11);
        frame(64, 0, 1'b1);
        check("strip count", 32'(got.size()), 32'h3C);
        check("strip last", {24'h0, got[59]}, 32'h3B);
        cfg(14'h05EE, 6'h00);
        frame(64, 0, 1'b0);
        check("off status", 32'(nStat), 32'h0);
        check("off bytes", 32'(got.size()), 32'h0);
    endtask

    task automatic t_size();
        cfg(14'h0064, 6'h01);
        frame(120, 0, 1'b1);
        check("cut flags", stat & 32'h1F0000, 32'h50000);
        check("cut len", stat & 32'h3FFF, 32'h65);
        frame(104, 1, 1'b1);
        check("no vlan allowance", stat & 32'h13FFF, 32'h10065);
        cfg(14'h0064, 6'h05);
        for (int t = 0; t < 3; t++) begin
            for (int x = 0; x < 2; x++) begin
                frame(100 + 4 * t + x, t, 1'b1);
                check("vlan flags", stat & 32'h1F0000,
                    {11'h0, t == 2, t > 0, x[0], 1'b0, x[0], 16'h0});
                check("vlan len", stat & 32'h3FFF, 32'(100 + 4 * t + x));
            end
        end
    endtask

    task automatic t_wdog();
        cfg(14'h05EE, 6'h21);
        frame(1600, 0, 1'b1);
        check("long kept", stat & 32'h1F3FFF, 32'h10640);
        frame(11300, 0, 1'b1);
        check("wdog flags", stat & 32'h1F0000, 32'h70000);
        check("wdog len", stat & 32'h3FFF, 32'h2C01);
    endtask

    task automatic t_disable();
        wr(ADDR_IRQ_CLEAR, 32'hF);
        wr(ADDR_RX_CTRL, 32'h05EE0022);
        repeat (2) @(negedge clk_sys);
        check("irq masked", {31'h0, irq}, 32'h0);
        rd(ADDR_RX_CTRL, 32'h05EE0022, "idle disable");
        wr(ADDR_RX_CTRL, 32'h05EE0023);
        wr(ADDR_IRQ_CLEAR, 32'hF);
        wr(ADDR_IRQ_ENABLE, 32'h8);
        @(negedge clk_sys);
        check("irq quiet", {31'h0, irq}, 32'h0);
        got.delete();
        nStat = 0;
        fork
            u_phy.send(40, 0);
            begin
                repeat (10) @(posedge clk_sys);
                wr(ADDR_RX_CTRL, 32'h05EE0020);
            end
        join
        check("frame finished", 32'(got.size()), 32'h28);
        check("finished status", 32'(nStat), 32'h1);
        rd(ADDR_RX_CTRL, 32'h05EE0022, "disabled flag");
        check("irq raised", {31'h0, irq}, 32'h1);
        rd(ADDR_IRQ_STATUS, 32'h9, "irq status");
        wr(ADDR_IRQ_CLEAR, 32'h8);
        @(negedge clk_sys);
        check("irq cleared", {31'h0, irq}, 32'h0);
        wr(ADDR_RX_CTRL, 32'h05EE0022);
        rd(ADDR_RX_CTRL, 32'h05EE0020, "disabled cleared");
    endtask

    initial begin
        reset = 1'b1;
        regAddr = 12'h000;
        regWrData = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        t_regs();
        t_pass();
        t_size();
        t_wdog();
        t_disable();
        summarize();
    end
endmodule
